// ---- rtl/conv_ctrl_pkg.sv ----
/*
 Package for the converter control block: register indices, field positions,
 reset values, timing constants and the packed structs that carry state.
 Assumes a 100 MHz system clock and a separate serial clock domain.
*/
package conv_ctrl_pkg;

   localparam int unsigned CLK_MHZ         = 100;
   localparam int unsigned POR_DELAY_US    = 250;
   localparam int unsigned POR_CYCLES      = POR_DELAY_US * CLK_MHZ;

   localparam int unsigned FRAME_BITS      = 24;
   localparam int unsigned CMD_BITS        = 8;
   localparam int unsigned DATA_BITS       = 16;

   localparam logic [3:0]  ADDR_SYNC       = 4'h2;
   localparam logic [3:0]  ADDR_PWR_CFG    = 4'h3;
   localparam logic [3:0]  ADDR_GAIN_DIV   = 4'h4;
   localparam logic [3:0]  ADDR_TRIGGER    = 4'h5;
   localparam logic [3:0]  ADDR_CODE       = 4'h8;

   localparam int unsigned SYNC_EN_BIT     = 0;
   localparam int unsigned AMP_PD_BIT      = 0;
   localparam int unsigned REF_PD_BIT      = 8;
   localparam int unsigned OUT_GAIN_BIT    = 0;
   localparam int unsigned REF_HALVE_BIT   = 8;
   localparam int unsigned LOAD_TRIG_BIT   = 4;
   localparam logic [3:0]  RESET_KEY_NIB   = 4'hA;
   localparam logic [15:0] RESET_KEY       = 16'h1010;

   localparam logic [15:0] SYNC_RST        = 16'h0000;
   localparam logic [15:0] PWR_CFG_RST     = 16'h0000;
   localparam logic [15:0] GAIN_DIV_RST    = 16'h0001;

   typedef struct packed {
      logic [CMD_BITS-1:0]  cmd;
      logic [DATA_BITS-1:0] data;
   } frame_t;

   typedef enum logic [1:0] {ST_POR, ST_RUN} ctl_state_t;

   typedef struct packed {
      ctl_state_t           st;
      logic [31:0]          por_cnt;
      logic                 if_two_wire;
      logic                 sync_en;
      logic                 amp_pd;
      logic                 ref_pd;
      logic                 ref_halve;
      logic                 gain_double;
      logic [15:0]          buf_code;
      logic [15:0]          act_code;
      logic [2:0]           tog_sync;
      logic                 tog_seen;
      logic [2:0]           alarm_sync;
      logic [2:0]           sel_sync;
      logic [15:0]          rd_data;
      logic                 out_zero;
      logic                 out_gnd;
   } core_t;

   typedef struct packed {
      logic [4:0]            cnt;
      logic [FRAME_BITS-1:0] shreg;
   } shift_t;

   typedef struct packed {
      frame_t frame;
      logic   tog;
   } hold_t;

endpackage : conv_ctrl_pkg

// ---- rtl/conv_ctrl.sv ----
/*
 Converter control core: three-wire write port, code and control registers,
 start-up delay and reference alarm handling.
 Assumes SCLK_IN clocks the serial receiver; FSELN_IN, SCLK_IN and DIN_IN come
 from the host; analog blocks consume the level outputs.
*/
// Functional notes
// - Output codes are unsigned straight binary, resolution bits, register 8h.
// - Reset loads code registers with zero or midscale depending on variant.
// - Reference-halve bit in 4h: divide by 1 when clear (default), 2 set.
// - Output-gain bit in 4h selects gain 1 or 2; default is 2.
// - Sync-load clear: buffer writes copy immediately to active code.
// - Serial mode immediate load changes output at frame-select rising edge.
// - Two-wire mode updates on final acknowledge falling edge (other block).
// - Sync-load set: active code updates only on load-trigger bit in 5h.
// - Reading the code register returns buffer contents, not active.
// - Internal reference on at reset; reference power-down bit in 3h disables.
// - Reference alarm forces output zero, keeps codes, recovers when fixed.
// - Power-on reset restores defaults; traffic ignored for 250 us after.
// - Output holds power-up level until first valid write changes the code.
// - Writing key 0x1010 to the trigger register starts a full reset.
// - Register 3h holds separate amplifier and reference power-downs, both off.
// - Amplifier powered down ties output to ground through 1 k resistor.
// - Interface-select pin sampled at the end of each start-up delay, key reset included; low serial, high two-wire.
// - Serial receiver has 24-bit shift register, up to 50 MHz clock.
// - Frame starts at frame-select fall; clock and data ignored while high.
// - Frame-select low for 24 falling edges; load on frame-select rise.
// - Early frame-select rise clears shift register and discards the frame.
// - Two-wire general call 0x00 0x06 resets device (two-wire block).
module conv_ctrl
   import conv_ctrl_pkg::*;
#(
   parameter int unsigned RES_BITS     = 16,
   parameter bit          MIDSCALE     = 1'b0,
   parameter int unsigned POR_WAIT     = POR_CYCLES
) (
   input  wire logic        CLK_IN,
   input  wire logic        RESETN_IN,
   input  wire logic        SCLK_IN,
   input  wire logic        FSELN_IN,
   input  wire logic        DIN_IN,
   input  wire logic        INTERFACE_SELECT_PIN_IN,
   input  wire logic        REF_ALARM_IN,
   output logic [15:0]      CODE_OUT,
   output logic [15:0]      READBACK_OUT,
   output logic             OUTPUT_GAIN_DOUBLE_OUT,
   output logic             REF_HALVE_OUT,
   output logic             REFERENCE_POWER_DOWN_OUT,
   output logic             AMP_POWER_DOWN_OUT,
   output logic             OUTPUT_TO_GROUND_OUT,
   output logic             OUTPUT_FORCE_ZERO_OUT,
   output logic             TWO_WIRE_MODE_OUT,
   output logic             READY_OUT
);

   initial begin
      if (!(RES_BITS == 12 || RES_BITS == 14 || RES_BITS == 16))
         $error("RES_BITS must be 12, 14 or 16");
      if (POR_WAIT < 1)
         $error("POR_WAIT must be at least 1");
   end

   // Reset code sits in the top RES_BITS of the 16-bit field
   localparam logic [15:0] CODE_RST = MIDSCALE ? 16'h8000 : 16'h0000;
   localparam logic [15:0] CODE_MASK = 16'hFFFF << (16 - RES_BITS);

   // Serial domain: shift register, clock and data ignored while frame-select high
   shift_t sh_q, sh_d;
   hold_t  hold_q, hold_d;

   always_comb begin
      sh_d   = sh_q;
      hold_d = hold_q;
      if (FSELN_IN) begin
         sh_d.cnt   = 5'h00;
         sh_d.shreg = '0;
      end else begin
         sh_d.shreg = {sh_q.shreg[FRAME_BITS-2:0], DIN_IN};
         if (sh_q.cnt != 5'(FRAME_BITS))
            sh_d.cnt = sh_q.cnt + 5'h01;
         if (sh_q.cnt == 5'(FRAME_BITS - 1)) begin
            hold_d.frame = frame_t'({sh_q.shreg[FRAME_BITS-2:0], DIN_IN});
            hold_d.tog   = ~hold_q.tog;
         end
      end
   end

   // Falling edges sample data; frame-select high asynchronously clears the counter
   always_ff @(negedge SCLK_IN or posedge FSELN_IN) begin
      if (FSELN_IN)
         sh_q <= '0;
      else
         sh_q <= sh_d;
   end

   // Without a reset the toggle would start unknown and no frame could ever be seen
   always_ff @(negedge SCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN)
         hold_q <= '0;
      else
         hold_q <= hold_d;
   end

   // Frame completion is only acted on once frame-select rises, seen in the core
   logic [2:0] fsel_sync_q;
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN)
         fsel_sync_q <= 3'b111;
      else
         fsel_sync_q <= {fsel_sync_q[1:0], FSELN_IN};
   end

   core_t c_q, c_d;
   frame_t fr;
   logic   fsel_rise;
   logic   new_frame;
   logic   soft_reset;

   always_comb begin
      c_d        = c_q;
      fr         = hold_q.frame;
      soft_reset = 1'b0;
      c_d.tog_sync   = {c_q.tog_sync[1:0], hold_q.tog};
      c_d.alarm_sync = {c_q.alarm_sync[1:0], REF_ALARM_IN};
      c_d.sel_sync   = {c_q.sel_sync[1:0], INTERFACE_SELECT_PIN_IN};
      fsel_rise = (fsel_sync_q[2] == 1'b0) && (fsel_sync_q[1] == 1'b1);
      new_frame = (c_q.tog_sync[2] == c_q.tog_sync[1]) && (c_q.tog_sync[1] != c_q.tog_seen);
      case (c_q.st)
         ST_POR: begin
            c_d.tog_seen = c_q.tog_sync[2];
            if (c_q.por_cnt == 32'(POR_WAIT - 1)) begin
               c_d.st          = ST_RUN;
               c_d.if_two_wire = c_q.sel_sync[2];
            end else begin
               c_d.por_cnt = c_q.por_cnt + 32'h1;
            end
         end
         ST_RUN: begin
            if (fsel_rise && new_frame && !c_q.if_two_wire) begin
               c_d.tog_seen = c_q.tog_sync[2];
               case (fr.cmd[3:0])
                  ADDR_SYNC: c_d.sync_en = fr.data[SYNC_EN_BIT];
                  ADDR_PWR_CFG: begin
                     c_d.amp_pd = fr.data[AMP_PD_BIT];
                     c_d.ref_pd = fr.data[REF_PD_BIT];
                  end
                  ADDR_GAIN_DIV: begin
                     c_d.ref_halve   = fr.data[REF_HALVE_BIT];
                     c_d.gain_double = fr.data[OUT_GAIN_BIT];
                  end
                  ADDR_TRIGGER: begin
                     if (fr.data == RESET_KEY)
                        soft_reset = 1'b1;
                     else if (fr.data[LOAD_TRIG_BIT] && c_q.sync_en)
                        c_d.act_code = c_q.buf_code;
                  end
                  ADDR_CODE: begin
                     c_d.buf_code = fr.data & CODE_MASK;
                     if (!c_q.sync_en)
                        c_d.act_code = fr.data & CODE_MASK;
                  end
                  default: ;
               endcase
            end else if (new_frame && fsel_sync_q[2]) begin
               c_d.tog_seen = c_q.tog_sync[2];
            end
         end
         default: c_d.st = ST_POR;
      endcase
      c_d.rd_data  = c_q.buf_code;
      c_d.out_zero = c_q.alarm_sync[2];
      c_d.out_gnd  = c_q.amp_pd;
      if (soft_reset) begin
         c_d          = '0;
         c_d.st       = ST_POR;
         c_d.tog_seen = c_q.tog_sync[2];
         c_d.tog_sync = c_q.tog_sync;
         c_d.sel_sync = c_q.sel_sync;
         c_d.if_two_wire = c_q.if_two_wire;
         c_d.alarm_sync = c_q.alarm_sync;
         c_d.out_zero = c_q.alarm_sync[2];
         c_d.out_gnd  = c_q.amp_pd;
         c_d.gain_double = GAIN_DIV_RST[OUT_GAIN_BIT];
         c_d.buf_code = CODE_RST;
         c_d.act_code = CODE_RST;
         c_d.rd_data  = CODE_RST;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         c_q             <= '0;
         c_q.st          <= ST_POR;
         c_q.sync_en     <= SYNC_RST[SYNC_EN_BIT];
         c_q.amp_pd      <= PWR_CFG_RST[AMP_PD_BIT];
         c_q.ref_pd      <= PWR_CFG_RST[REF_PD_BIT];
         c_q.ref_halve   <= GAIN_DIV_RST[REF_HALVE_BIT];
         c_q.gain_double <= GAIN_DIV_RST[OUT_GAIN_BIT];
         c_q.buf_code    <= CODE_RST;
         c_q.act_code    <= CODE_RST;
         c_q.rd_data     <= CODE_RST;
      end else begin
         c_q <= c_d;
      end
   end

   assign CODE_OUT                 = c_q.act_code;
   assign READBACK_OUT             = c_q.rd_data;
   assign OUTPUT_GAIN_DOUBLE_OUT   = c_q.gain_double;
   assign REF_HALVE_OUT            = c_q.ref_halve;
   assign REFERENCE_POWER_DOWN_OUT = c_q.ref_pd;
   assign AMP_POWER_DOWN_OUT       = c_q.amp_pd;
   assign OUTPUT_TO_GROUND_OUT     = c_q.out_gnd;
   assign OUTPUT_FORCE_ZERO_OUT    = c_q.out_zero;
   assign TWO_WIRE_MODE_OUT        = c_q.if_two_wire;
   assign READY_OUT                = (c_q.st == ST_RUN);

endmodule : conv_ctrl

// ---- testbench/conv_ctrl_sva.sv ----
/* Port assertions for the converter control block.
   Assumes it is bound to conv_ctrl and sampled on CLK_IN. */
module conv_ctrl_sva
   import conv_ctrl_pkg::*;
#(
   parameter bit MIDSCALE = 1'b0
) (
   input wire logic        CLK_IN,
   input wire logic        RESETN_IN,
   input wire logic        FSELN_IN,
   input wire logic        REF_ALARM_IN,
   input wire logic [15:0] CODE_OUT,
   input wire logic [15:0] READBACK_OUT,
   input wire logic        OUTPUT_GAIN_DOUBLE_OUT,
   input wire logic        REF_HALVE_OUT,
   input wire logic        REFERENCE_POWER_DOWN_OUT,
   input wire logic        AMP_POWER_DOWN_OUT,
   input wire logic        OUTPUT_TO_GROUND_OUT,
   input wire logic        OUTPUT_FORCE_ZERO_OUT,
   input wire logic        TWO_WIRE_MODE_OUT,
   input wire logic        READY_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] since_q;
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   // Frame end is asynchronous here, so the window allows up to 10 cycles where the design needs 2 or 3
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN || $rose(FSELN_IN)) since_q <= (RESETN_IN ? 4'h0 : 4'hF);
      else if (since_q != 4'hF) since_q <= since_q + 4'h1;
   end
   gnd_tie_a: assert property (OUTPUT_TO_GROUND_OUT == $past(AMP_POWER_DOWN_OUT))
      else $error("ground tie does not follow amplifier power-down");
   alarm_on_a: assert property (REF_ALARM_IN [*6] |-> OUTPUT_FORCE_ZERO_OUT)
      else $error("alarm did not force zero");
   alarm_off_a: assert property (!REF_ALARM_IN [*6] |-> !OUTPUT_FORCE_ZERO_OUT)
      else $error("force zero without alarm");
   por_default_a: assert property (!READY_OUT |->
      CODE_OUT == (MIDSCALE ? 16'h8000 : 16'h0000) && OUTPUT_GAIN_DOUBLE_OUT
      && !REF_HALVE_OUT && !REFERENCE_POWER_DOWN_OUT && !AMP_POWER_DOWN_OUT)
      else $error("defaults not held during start-up");
   code_when_a: assert property ($changed(CODE_OUT) |-> since_q <= 4'hA)
      else $error("code changed away from a frame end");
   rdbk_when_a: assert property ($changed(READBACK_OUT) |-> since_q <= 4'hA)
      else $error("readback changed away from a frame end");
   mode_hold_a: assert property ($past(READY_OUT) |-> $stable(TWO_WIRE_MODE_OUT))
      else $error("interface mode changed after start-up");
   two_wire_a: assert property (TWO_WIRE_MODE_OUT && $past(TWO_WIRE_MODE_OUT)
      |-> $stable(CODE_OUT))
      else $error("serial frame accepted in two-wire mode");
   cover property (OUTPUT_FORCE_ZERO_OUT);
   cover property ($changed(CODE_OUT));
   cover property (AMP_POWER_DOWN_OUT && REFERENCE_POWER_DOWN_OUT);
endmodule : conv_ctrl_sva

// ---- testbench/spi_host.sv ----
/* Serial host model: frame select, gated 48 ns serial clock, data.
   Assumes the device samples data on falling serial clock edges. */
module spi_host;
   timeunit 1ns;
   timeprecision 1ps;
   logic sclk  = 1'b1;
   logic fseln = 1'b1;
   logic din   = 1'b0;
   // Clock stands still outside frames; n below 24 aborts the frame on purpose
   task automatic send(input logic [23:0] f, input int n);
      #7 fseln = 1'b0;
      for (int i = 23; i > 23 - n; i--) begin
         din = f[i];
         #24 sclk = 1'b0;
         #24 sclk = 1'b1;
      end
      #10 fseln = 1'b1;
      din = ~din;
      #200;
   endtask : send
endmodule : spi_host

// ---- testbench/tb_conv_ctrl.sv ----
/* Self-checking bench for conv_ctrl against a register model.
   Assumes the host model in spi_host and a shortened start-up delay. */
module tb_conv_ctrl;
   import conv_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned PW = 400;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sel = 1'b0;
   logic        alarm = 1'b0;
   logic [15:0] code, rdbk, m_buf, m_act;
   logic        gain, halve, refpd, amppd, gnd, fz, twm, ready;
   logic        m_sync, m_amp, m_ref, m_gain, m_halve, m_al, m_on;
   int          miscompares = 0;
   int          compares = 0;
   int          seed = 32'h8529;
   int          cyc = 0;
   spi_host host();
   conv_ctrl #(.POR_WAIT(PW)) u_dut (.CLK_IN(clk), .RESETN_IN(rst_n),
      .SCLK_IN(host.sclk), .FSELN_IN(host.fseln), .DIN_IN(host.din),
      .INTERFACE_SELECT_PIN_IN(sel), .REF_ALARM_IN(alarm), .CODE_OUT(code),
      .READBACK_OUT(rdbk), .OUTPUT_GAIN_DOUBLE_OUT(gain), .REF_HALVE_OUT(halve),
      .REFERENCE_POWER_DOWN_OUT(refpd), .AMP_POWER_DOWN_OUT(amppd),
      .OUTPUT_TO_GROUND_OUT(gnd), .OUTPUT_FORCE_ZERO_OUT(fz),
      .TWO_WIRE_MODE_OUT(twm), .READY_OUT(ready));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic chkb(input string n, input logic e, input logic g);
      chk(n, {15'h0, e}, {15'h0, g});
   endtask : chkb
   task automatic mreset;
      {m_buf, m_act, m_sync, m_amp, m_ref, m_halve} = '0;
      m_gain = 1'b1;
   endtask : mreset
   task automatic check_all;
      chk("code", m_act, code);
      chk("readback", m_buf, rdbk);
      chkb("gain", m_gain, gain);
      chkb("halve", m_halve, halve);
      chkb("refpd", m_ref, refpd);
      chkb("amppd", m_amp, amppd);
      chkb("ground", m_amp, gnd);
      chkb("zero", m_al, fz);
      chkb("mode", sel, twm);
      chkb("ready", m_on, ready);
   endtask : check_all
   task automatic wait_ready;
      for (int k = 0; k < PW + 50 && ready !== 1'b1; k++) @(posedge clk);
      m_on = 1'b1;
      check_all();
   endtask : wait_ready
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input int n);
      host.send({4'h0, a, d}, n);
      repeat (8) @(posedge clk);
      if (n == 24 && m_on && !sel) case (a)
         4'h2: m_sync = d[0];
         4'h3: {m_ref, m_amp} = {d[8], d[0]};
         4'h4: {m_halve, m_gain} = {d[8], d[0]};
         4'h5: if (d == 16'h1010) {m_on, m_buf, m_act, m_sync, m_amp, m_ref, m_halve, m_gain} = 38'h1;
            else if (d[4]) m_act = m_buf;
         4'h8: {m_buf, m_act} = {d, m_sync ? m_act : d};
         default: ;
      endcase
      if (!sel) check_all();
   endtask : wr
   task automatic summarize;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize
   initial begin
      mreset();
      {m_al, m_on} = 2'b00;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check_all();
      wr(4'h8, 16'h1234, 24);
      wait_ready();
      for (int i = 0; i < 4; i++) wr(4'h8, 16'($random(seed)), 24);
      for (int i = 0; i < 3; i++) wr(4'h8, 16'hFFFF, 1 + 11 * i);
      $display("test writes done");
      wr(4'h2, 16'h0001, 24);
      wr(4'h8, 16'hA5A5, 24);
      wr(4'h5, 16'h0010, 24);
      wr(4'h2, 16'h0000, 24);
      wr(4'h4, 16'h0100, 24);
      wr(4'h3, 16'h0101, 24);
      wr(4'h3, 16'h0000, 24);
      $display("test modes done");
      alarm <= 1'b1;
      m_al = 1'b1;
      repeat (8) @(posedge clk);
      check_all();
      alarm <= 1'b0;
      m_al = 1'b0;
      repeat (8) @(posedge clk);
      check_all();
      wr(4'h5, 16'h1010, 24);
      wait_ready();
      $display("test resets done");
      rst_n <= 1'b0;
      mreset();
      m_on = 1'b0;
      sel <= 1'b1;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      wait_ready();
      wr(4'h8, 16'h5555, 24);
      check_all();
      $display("test two-wire done");
      summarize();
   end
endmodule : tb_conv_ctrl
bind conv_ctrl conv_ctrl_sva #(.MIDSCALE(MIDSCALE)) u_sva (.CLK_IN, .RESETN_IN, .FSELN_IN,
   .REF_ALARM_IN, .CODE_OUT, .READBACK_OUT, .OUTPUT_GAIN_DOUBLE_OUT, .REF_HALVE_OUT,
   .REFERENCE_POWER_DOWN_OUT, .AMP_POWER_DOWN_OUT, .OUTPUT_TO_GROUND_OUT,
   .OUTPUT_FORCE_ZERO_OUT, .TWO_WIRE_MODE_OUT, .READY_OUT);
